/* hdl/pemffl_pkg.sv */
// package: offsets, field layouts and carriers of the error mask and first-fatal log block
package pemffl_pkg;

  // ----------------------------------------
  // configuration offsets and widths
  // ----------------------------------------
  localparam int          ADDR_W      = 12;
  localparam int          DATA_W      = 32;
  localparam int          BE_W        = DATA_W / 8;
  localparam int          LOG_W       = 13;
  localparam logic [11:0] OFF_COR_MSK = 12'h14C;
  localparam logic [11:0] OFF_RP_MSK  = 12'h150;
  localparam logic [11:0] OFF_FAT_LOG = 12'h154;

  // ----------------------------------------
  // correctable detect mask bits
  // ----------------------------------------
  localparam int          COR_RPL_TO   = 12;
  localparam int          COR_RPL_ROLL = 8;
  localparam int          COR_BAD_DLLP = 7;
  localparam int          COR_BAD_TLP  = 6;
  localparam int          COR_RX_ERR   = 0;
  localparam logic [31:0] COR_WMASK    = 32'h0000_11C1;
  localparam logic [31:0] COR_RESET    = 32'h0000_0000;

  // ----------------------------------------
  // root-port message detect mask bits
  // ----------------------------------------
  localparam int          RP_FAT_MSG = 2;
  localparam int          RP_UNC_MSG = 1;
  localparam int          RP_COR_MSG = 0;
  localparam logic [31:0] RP_WMASK   = 32'h0000_0007;
  localparam logic [31:0] RP_RESET   = 32'h0000_0000;

  // ----------------------------------------
  // first-fatal log bits
  // ----------------------------------------
  localparam int           LOG_LINK_DOWN = 12;
  localparam int           LOG_SOUTH_TO  = 11;
  localparam int           LOG_MALFORMED = 10;
  localparam int           LOG_RX_OVF    = 9;
  localparam int           LOG_UNEXP_CPL = 8;
  localparam int           LOG_CPL_ABORT = 7;
  localparam int           LOG_CPL_TO    = 6;
  localparam int           LOG_FC_PROTO  = 5;
  localparam int           LOG_POISONED  = 4;
  localparam int           LOG_TRAINING  = 3;
  localparam int           LOG_UNSUP_REQ = 2;
  localparam int           LOG_FAT_MSG   = 1;
  localparam int           LOG_DL_PROTO  = 0;
  localparam logic [12:0]  LOG_RESET     = 13'h0000;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic replay_timeout;
    logic replay_rollover;
    logic bad_link_packet;
    logic bad_transaction_packet;
    logic receiver_error;
  } pemffl_cor_s;

  typedef struct packed {
    logic fatal_message;
    logic uncorrectable_message;
    logic correctable_message;
  } pemffl_msg_s;

  typedef struct packed {
    logic link_down;
    logic south_link_reset_timeout;
    logic malformed;
    logic rx_overflow;
    logic unexpected_completion;
    logic completer_abort;
    logic completion_timeout;
    logic flow_control_protocol;
    logic poisoned;
    logic training;
    logic unsupported_request;
    logic data_link_protocol;
  } pemffl_unc_s;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [11:0]       addr;
    logic [31:0]       wdata;
    logic [3:0]        be;
  } pemffl_cfg_s;

endpackage : pemffl_pkg

/* hdl/pemffl_detect.sv */
// module: masked event detector with registered output
module pemffl_detect #(
  parameter int W = 5
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] evt_i,
  input  wire logic [W-1:0] mask_i,
  output logic      [W-1:0] det_o
);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  if (W < 1) begin : g_bad_w
    $error("detector width must be at least one");
  end

  // ----------------------------------------
  // detection
  // ----------------------------------------
  // a set mask bit hides its event entirely
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
      det_o <= '0;
    else
      det_o <= evt_i & ~mask_i;
  end

endmodule : pemffl_detect

/* hdl/pemffl_log.sv */
// module: sticky write-one-to-clear log, set wins over clear
module pemffl_log #(
  parameter int W = 13
) (
  input  wire logic         sys_clk_i,
  input  wire logic         sticky_rstn_i,
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] clr_i,
  output logic      [W-1:0] log_o
);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  if (W < 1) begin : g_bad_w
    $error("log width must be at least one");
  end

  // ----------------------------------------
  // log bits
  // ----------------------------------------
  // only the power-on reset clears; warm reset leaves the log alone
  always_ff @(posedge sys_clk_i)
  begin
    if (!sticky_rstn_i)
      log_o <= '0;
    else
      log_o <= (log_o & ~clr_i) | set_i;
  end

endmodule : pemffl_log

/* hdl/pemffl_top.sv */
// module: correctable and message detect masks plus first-fatal error log
// Function
// - The correctable mask resets to zero and a set bit stops detection of its error type.
// - Correctable mask bit 12 hides replay timer time-outs and bit 8 hides replay rollovers.
// - Correctable mask bit 7 hides bad link packets and bit 6 hides bad transaction packets.
// - Correctable mask bit 0 hides receiver errors and all other bits are reserved.
// - The message mask resets to zero and blocks received error messages of each chosen class.
// - Message mask bit 2 blocks fatal, bit 1 uncorrectable and bit 0 correctable messages.
// - The first-fatal log records the first unmasked fatal error of each type.
// - Hardware sets a log bit only when it is clear or being cleared that cycle, so later errors leave the log unchanged.
// - An uncorrectable error counts as fatal only by its level in the severity select.
// - Log bit 12 is surprise link down, bit 11 south link reset time-out, bit 10 malformed packet.
// - Log bit 9 is receive overflow, bit 8 unexpected completion, bit 7 completer abort.
// - Log bit 6 is completion timeout, bit 5 flow control error, bit 4 poisoned packet.
// - Log bit 3 is training error, bit 2 unsupported request, bit 1 received fatal message.
// - Log bit 0 is link protocol error and bits 31 to 13 read as zero.
// - A masked error is neither reported nor logged anywhere.
module pemffl_top (
  input  wire logic                          sys_clk_i,
  input  wire logic                          rstn_i,
  input  wire logic                          sticky_rstn_i,
  input  wire pemffl_pkg::pemffl_cfg_s       cfg_i,
  output logic      [31:0]                   cfg_rdata_o,
  output logic                               cfg_rvalid_o,
  input  wire pemffl_pkg::pemffl_cor_s       cor_evt_i,
  input  wire pemffl_pkg::pemffl_msg_s       msg_evt_i,
  input  wire pemffl_pkg::pemffl_unc_s       unc_evt_i,
  input  wire pemffl_pkg::pemffl_unc_s       unc_mask_i,
  input  wire pemffl_pkg::pemffl_unc_s       uncorrectable_severity_select_i,
  output pemffl_pkg::pemffl_cor_s            cor_det_o,
  output pemffl_pkg::pemffl_msg_s            msg_det_o,
  output logic      [12:0]                   fatal_det_o,
  output logic      [12:0]                   nonfatal_det_o,
  output logic      [12:0]                   first_fatal_error_log_o
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  // true for an access that hits the given offset
  function automatic logic hit(input pemffl_pkg::pemffl_cfg_s c, input logic [11:0] off);
    hit = c.addr[11:2] == off[11:2];
  endfunction : hit

  // byte-enable expansion of a write
  function automatic logic [31:0] lanes(input logic [3:0] be);
    for (int i = 0; i < pemffl_pkg::BE_W; i++)
      lanes[i*8 +: 8] = {8{be[i]}};
  endfunction : lanes

  // places uncorrectable types and the fatal message into log order
  function automatic logic [12:0] to_log(input pemffl_pkg::pemffl_unc_s u, input logic fmsg);
    to_log = '0;
    to_log[pemffl_pkg::LOG_LINK_DOWN] = u.link_down;
    to_log[pemffl_pkg::LOG_SOUTH_TO]  = u.south_link_reset_timeout;
    to_log[pemffl_pkg::LOG_MALFORMED] = u.malformed;
    to_log[pemffl_pkg::LOG_RX_OVF]    = u.rx_overflow;
    to_log[pemffl_pkg::LOG_UNEXP_CPL] = u.unexpected_completion;
    to_log[pemffl_pkg::LOG_CPL_ABORT] = u.completer_abort;
    to_log[pemffl_pkg::LOG_CPL_TO]    = u.completion_timeout;
    to_log[pemffl_pkg::LOG_FC_PROTO]  = u.flow_control_protocol;
    to_log[pemffl_pkg::LOG_POISONED]  = u.poisoned;
    to_log[pemffl_pkg::LOG_TRAINING]  = u.training;
    to_log[pemffl_pkg::LOG_UNSUP_REQ] = u.unsupported_request;
    to_log[pemffl_pkg::LOG_FAT_MSG]   = fmsg;
    to_log[pemffl_pkg::LOG_DL_PROTO]  = u.data_link_protocol;
  endfunction : to_log

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [31:0] correctable_error_detect_mask_r;
  logic [31:0] root_port_message_detect_mask_r;
  logic [31:0] wr_bits;
  logic        wr_cor;
  logic        wr_rp;
  logic        wr_log;
  logic [12:0] log_clr;
  logic [12:0] log_set;
  logic [12:0] unc_seen;
  logic [12:0] sev_vec;
  logic [4:0]  cor_mask;
  logic [2:0]  msg_mask;
  logic        fmsg_seen;

  // write decode
  assign wr_bits = lanes(cfg_i.be) & cfg_i.wdata;
  assign wr_cor  = cfg_i.wr && hit(cfg_i, pemffl_pkg::OFF_COR_MSK);
  assign wr_rp   = cfg_i.wr && hit(cfg_i, pemffl_pkg::OFF_RP_MSK);
  assign wr_log  = cfg_i.wr && hit(cfg_i, pemffl_pkg::OFF_FAT_LOG);

  // ----------------------------------------
  // detect masks
  // ----------------------------------------
  // correctable mask, reserved bits stay zero
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
      correctable_error_detect_mask_r <= pemffl_pkg::COR_RESET;
    else if (wr_cor)
      correctable_error_detect_mask_r <=
        (correctable_error_detect_mask_r & ~(lanes(cfg_i.be) & pemffl_pkg::COR_WMASK))
        | (wr_bits & pemffl_pkg::COR_WMASK);
  end

  // message mask, reserved bits stay zero
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
      root_port_message_detect_mask_r <= pemffl_pkg::RP_RESET;
    else if (wr_rp)
      root_port_message_detect_mask_r <=
        (root_port_message_detect_mask_r & ~(lanes(cfg_i.be) & pemffl_pkg::RP_WMASK))
        | (wr_bits & pemffl_pkg::RP_WMASK);
  end

  // mask bits in struct order
  assign cor_mask = {correctable_error_detect_mask_r[pemffl_pkg::COR_RPL_TO],
                     correctable_error_detect_mask_r[pemffl_pkg::COR_RPL_ROLL],
                     correctable_error_detect_mask_r[pemffl_pkg::COR_BAD_DLLP],
                     correctable_error_detect_mask_r[pemffl_pkg::COR_BAD_TLP],
                     correctable_error_detect_mask_r[pemffl_pkg::COR_RX_ERR]};
  assign msg_mask = {root_port_message_detect_mask_r[pemffl_pkg::RP_FAT_MSG],
                     root_port_message_detect_mask_r[pemffl_pkg::RP_UNC_MSG],
                     root_port_message_detect_mask_r[pemffl_pkg::RP_COR_MSG]};

  // correctable detection
  pemffl_detect #(
    .W      (5)
  ) u_cor_det (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .evt_i     (cor_evt_i),
    .mask_i    (cor_mask),
    .det_o     (cor_det_o)
  );

  // received message detection
  pemffl_detect #(
    .W      (3)
  ) u_msg_det (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .evt_i     (msg_evt_i),
    .mask_i    (msg_mask),
    .det_o     (msg_det_o)
  );

  // ----------------------------------------
  // fatal classification
  // ----------------------------------------
  // unmasked events only; fatal message is fatal by definition
  assign fmsg_seen    = msg_evt_i.fatal_message && !msg_mask[2];
  assign unc_seen     = to_log(unc_evt_i & ~unc_mask_i, fmsg_seen);
  assign sev_vec      = to_log(uncorrectable_severity_select_i, 1'b1);
  // a bit being cleared this cycle counts as free, so a new fatal still lands
  assign log_set      = unc_seen & sev_vec & ~(first_fatal_error_log_o & ~log_clr);

  // registered classification outputs
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      fatal_det_o    <= '0;
      nonfatal_det_o <= '0;
    end
    else
    begin
      fatal_det_o    <= unc_seen & sev_vec;
      nonfatal_det_o <= unc_seen & ~sev_vec;
    end
  end

  // ----------------------------------------
  // first-fatal log
  // ----------------------------------------
  // write one clears, a new fatal in the same cycle wins
  assign log_clr = wr_log ? wr_bits[12:0] : '0;

  pemffl_log #(
    .W      (pemffl_pkg::LOG_W)
  ) u_log (
    .sys_clk_i     (sys_clk_i),
    .sticky_rstn_i (sticky_rstn_i),
    .set_i         (log_set),
    .clr_i         (log_clr),
    .log_o         (first_fatal_error_log_o)
  );

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // one-cycle read answer, unmapped offsets read zero
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      cfg_rdata_o  <= '0;
      cfg_rvalid_o <= 1'b0;
    end
    else
    begin
      cfg_rvalid_o <= cfg_i.rd;
      if (!cfg_i.rd)
        cfg_rdata_o <= '0;
      else if (hit(cfg_i, pemffl_pkg::OFF_COR_MSK))
        cfg_rdata_o <= correctable_error_detect_mask_r;
      else if (hit(cfg_i, pemffl_pkg::OFF_RP_MSK))
        cfg_rdata_o <= root_port_message_detect_mask_r;
      else if (hit(cfg_i, pemffl_pkg::OFF_FAT_LOG))
        cfg_rdata_o <= {19'h00000, first_fatal_error_log_o};
      else
        cfg_rdata_o <= '0;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i || !sticky_rstn_i);

  cor_mask_hides_a: assert property (
    correctable_error_detect_mask_r[pemffl_pkg::COR_RPL_TO] && cor_evt_i.replay_timeout
    ##0 $stable(correctable_error_detect_mask_r) |=> !cor_det_o.replay_timeout)
    else $error("masked replay time-out was detected");

  cor_clear_sees_a: assert property (
    !correctable_error_detect_mask_r[pemffl_pkg::COR_BAD_TLP] && cor_evt_i.bad_transaction_packet
    |=> cor_det_o.bad_transaction_packet)
    else $error("unmasked bad packet was lost");

  cor_reserved_zero_a: assert property (
    (correctable_error_detect_mask_r & ~pemffl_pkg::COR_WMASK) == '0)
    else $error("reserved correctable mask bit set");

  rp_mask_blocks_a: assert property (
    msg_evt_i.correctable_message && root_port_message_detect_mask_r[pemffl_pkg::RP_COR_MSG]
    |=> !msg_det_o.correctable_message)
    else $error("masked correctable message detected");

  log_first_only_a: assert property (
    first_fatal_error_log_o[pemffl_pkg::LOG_FAT_MSG] && !(wr_log && wr_bits[pemffl_pkg::LOG_FAT_MSG])
    |=> first_fatal_error_log_o[pemffl_pkg::LOG_FAT_MSG])
    else $error("logged fatal bit dropped without a clear");

  log_fatal_capture_a: assert property (
    unc_evt_i.link_down && !unc_mask_i.link_down && uncorrectable_severity_select_i.link_down
    |=> first_fatal_error_log_o[pemffl_pkg::LOG_LINK_DOWN] ##0 fatal_det_o[pemffl_pkg::LOG_LINK_DOWN])
    else $error("fatal link down not logged");

  log_nonfatal_skip_a: assert property (
    unc_evt_i.poisoned && !uncorrectable_severity_select_i.poisoned
    && !first_fatal_error_log_o[pemffl_pkg::LOG_POISONED]
    |=> !first_fatal_error_log_o[pemffl_pkg::LOG_POISONED])
    else $error("non-fatal error reached the fatal log");

  log_masked_skip_a: assert property (
    unc_mask_i.malformed && !first_fatal_error_log_o[pemffl_pkg::LOG_MALFORMED]
    |=> !first_fatal_error_log_o[pemffl_pkg::LOG_MALFORMED] ##0 !fatal_det_o[pemffl_pkg::LOG_MALFORMED])
    else $error("masked error was logged");

  log_w1c_a: assert property (
    wr_log && wr_bits[pemffl_pkg::LOG_CPL_TO] && !log_set[pemffl_pkg::LOG_CPL_TO]
    |=> !first_fatal_error_log_o[pemffl_pkg::LOG_CPL_TO])
    else $error("write one did not clear the log bit");

  read_answer_a: assert property (
    cfg_i.rd && hit(cfg_i, pemffl_pkg::OFF_FAT_LOG)
    |=> cfg_rvalid_o ##0 cfg_rdata_o == {19'h00000, $past(first_fatal_error_log_o)})
    else $error("log read returned wrong data");

  log_set_wins_a: assert property (
    wr_log && wr_bits[pemffl_pkg::LOG_LINK_DOWN]
    && unc_seen[pemffl_pkg::LOG_LINK_DOWN] && sev_vec[pemffl_pkg::LOG_LINK_DOWN]
    |=> first_fatal_error_log_o[pemffl_pkg::LOG_LINK_DOWN])
    else $error("same-cycle clear beat a new fatal error");

  msg_fatal_log_a: assert property (
    msg_evt_i.fatal_message && !root_port_message_detect_mask_r[pemffl_pkg::RP_FAT_MSG]
    |=> first_fatal_error_log_o[pemffl_pkg::LOG_FAT_MSG] ##0 fatal_det_o[pemffl_pkg::LOG_FAT_MSG])
    else $error("unmasked fatal message not logged");

  cor_roll_hides_a: assert property (
    correctable_error_detect_mask_r[pemffl_pkg::COR_RPL_ROLL] && cor_evt_i.replay_rollover
    |=> !cor_det_o.replay_rollover)
    else $error("masked replay rollover was detected");

  cor_rx_hides_a: assert property (
    correctable_error_detect_mask_r[pemffl_pkg::COR_RX_ERR] && cor_evt_i.receiver_error
    |=> !cor_det_o.receiver_error)
    else $error("masked receiver error was detected");

  rp_fatal_blocks_a: assert property (
    msg_evt_i.fatal_message && root_port_message_detect_mask_r[pemffl_pkg::RP_FAT_MSG]
    |=> !msg_det_o.fatal_message)
    else $error("masked fatal message detected");

  // ----------------------------------------
  // covers
  // ----------------------------------------
  cov_log_set_c:   cover property (|log_set);
  cov_set_clr_c:   cover property (|(log_set & log_clr));
  cov_cor_mask_c:  cover property (wr_cor ##1 |cor_mask);
  cov_msg_block_c: cover property (msg_evt_i.fatal_message && msg_mask[2]);

endmodule : pemffl_top

/* tb/pcie_error_mask_first_fatal_log_tb.sv */
// testbench: masks, detector outputs and first-fatal log checked against a bench model
module pcie_error_mask_first_fatal_log_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // design ports and bench model
  // ----------------------------------------
  logic                    sys_clk_i;
  logic                    rstn_i;
  logic                    sticky_rstn_i;
  pemffl_pkg::pemffl_cfg_s cfg_i;
  logic [31:0]             cfg_rdata_o;
  logic                    cfg_rvalid_o;
  pemffl_pkg::pemffl_cor_s cor_evt_i;
  pemffl_pkg::pemffl_cor_s cor_det_o;
  pemffl_pkg::pemffl_msg_s msg_evt_i;
  pemffl_pkg::pemffl_msg_s msg_det_o;
  pemffl_pkg::pemffl_unc_s unc_evt_i;
  pemffl_pkg::pemffl_unc_s unc_mask_i;
  pemffl_pkg::pemffl_unc_s sev_i;
  logic [12:0]             fatal_det_o;
  logic [12:0]             nonfatal_det_o;
  logic [12:0]             log_o;
  logic [31:0]             cor_msk;
  logic [31:0]             rp_msk;
  logic [12:0]             log_m;
  logic [11:0]             adr [4];
  logic [46:0]             det_q [$];
  logic [31:0]             rd_q [$];
  logic                    evt_live;
  logic [31:0]             r0;
  logic [31:0]             r1;
  logic [31:0]             r2;
  int                      bad_count;
  int                      num_checks;
  integer                  seed;

  pemffl_top dut (
    .sys_clk_i                       (sys_clk_i),
    .rstn_i                          (rstn_i),
    .sticky_rstn_i                   (sticky_rstn_i),
    .cfg_i                           (cfg_i),
    .cfg_rdata_o                     (cfg_rdata_o),
    .cfg_rvalid_o                    (cfg_rvalid_o),
    .cor_evt_i                       (cor_evt_i),
    .msg_evt_i                       (msg_evt_i),
    .unc_evt_i                       (unc_evt_i),
    .unc_mask_i                      (unc_mask_i),
    .uncorrectable_severity_select_i (sev_i),
    .cor_det_o                       (cor_det_o),
    .msg_det_o                       (msg_det_o),
    .fatal_det_o                     (fatal_det_o),
    .nonfatal_det_o                  (nonfatal_det_o),
    .first_fatal_error_log_o         (log_o)
  );

  // 20 MHz core clock
  initial
  begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  // ----------------------------------------
  // compare, verdict and read model
  // ----------------------------------------
  task automatic check(input string what, input logic [46:0] exp, input logic [46:0] got);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict

  function automatic logic [31:0] rd_val(input logic [11:0] a);
    if (a == adr[0])
      return cor_msk;
    if (a == adr[1])
      return rp_msk;
    if (a == adr[2])
      return {19'h0, log_m};
    return 32'h0;  // unmapped reads return zero
  endfunction : rd_val

  // ----------------------------------------
  // driver: one cycle of bus and events, expectations queued
  // ----------------------------------------
  task automatic cyc(input logic wr, input logic rd, input int ai, input logic [31:0] wd, input logic [3:0] be,
                     input logic [4:0] ce, input logic [2:0] me, input logic [11:0] ue, input logic [11:0] um,
                     input logic [11:0] sv);
    logic [31:0] wm;
    logic [4:0]  cm;
    logic [2:0]  md;
    logic [11:0] uu;
    logic [12:0] fat;
    logic [12:0] nf;
    logic [12:0] clr;
    wm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    cfg_i = '{wr: wr, rd: rd, addr: adr[ai], wdata: wd, be: be};
    cor_evt_i = ce;
    msg_evt_i = me;
    unc_evt_i = ue;
    unc_mask_i = um;
    sev_i = sv;
    evt_live = 1'b1;
    cm = {cor_msk[12], cor_msk[8], cor_msk[7], cor_msk[6], cor_msk[0]};
    md = me & ~rp_msk[2:0];
    uu = ue & ~um;
    fat = {uu[11:1] & sv[11:1], md[2], uu[0] & sv[0]};
    nf = {uu[11:1] & ~sv[11:1], 1'b0, uu[0] & ~sv[0]};
    clr = 13'h0;
    if (rd)
      rd_q.push_back(rd_val(adr[ai]));  // read sees the value before a same-cycle write
    if (wr && ai == 0)
      cor_msk = ((cor_msk & ~wm) | (wd & wm)) & pemffl_pkg::COR_WMASK;
    if (wr && ai == 1)
      rp_msk = ((rp_msk & ~wm) | (wd & wm)) & pemffl_pkg::RP_WMASK;
    if (wr && ai == 2)
      clr = wd[12:0] & wm[12:0];
    log_m = (log_m & ~clr) | fat;  // set wins over a same-cycle clear
    det_q.push_back({ce & ~cm, md, fat, nf, log_m});
    @(negedge sys_clk_i);
  endtask : cyc

  task automatic reg_wr(input int ai, input logic [31:0] d, input logic [3:0] be);
    cyc(1'b1, 1'b0, ai, d, be, 5'h0, 3'h0, 12'h0, 12'h0, 12'hFFF);
  endtask : reg_wr

  task automatic reg_rd(input int ai);
    cyc(1'b0, 1'b1, ai, 32'h0, 4'h0, 5'h0, 3'h0, 12'h0, 12'h0, 12'hFFF);
  endtask : reg_rd

  task automatic evt(input logic [4:0] ce, input logic [2:0] me, input logic [11:0] ue, input logic [11:0] um,
                     input logic [11:0] sv);
    cyc(1'b0, 1'b0, 0, 32'h0, 4'h0, ce, me, ue, um, sv);
  endtask : evt

  // inputs idle, masks cleared; log cleared only by the power-on reset
  task automatic do_reset(input logic sticky, input int n);
    cfg_i = '0;
    cor_evt_i = '0;
    msg_evt_i = '0;
    unc_evt_i = '0;
    unc_mask_i = '0;
    sev_i = '0;
    evt_live = 1'b0;
    rstn_i = 1'b0;
    sticky_rstn_i = ~sticky;
    cor_msk = 32'h0;
    rp_msk = 32'h0;
    if (sticky)
      log_m = 13'h0;
    repeat (n) @(negedge sys_clk_i);
    rstn_i = 1'b1;
    sticky_rstn_i = 1'b1;
  endtask : do_reset

  // ----------------------------------------
  // monitor: takes the oldest note when a result appears
  // ----------------------------------------
  always @(posedge sys_clk_i)
  begin
    #5;
    if (cfg_rvalid_o === 1'b1)
      check("cfg_rdata_o", (rd_q.size() > 0) ? {15'h0, rd_q.pop_front()} : {15'h7FFF, 32'h0},
            {15'h0, cfg_rdata_o});
    if (evt_live === 1'b1 && det_q.size() > 0)
      check("detect and log", det_q.pop_front(),
            {cor_det_o, msg_det_o, fatal_det_o, nonfatal_det_o, log_o});
  end

  // watchdog on the whole run
  initial
  begin
    repeat (5000) @(posedge sys_clk_i);
    bad_count++;
    $display("Error run length expected below 5000 seen 5000");
    print_verdict();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    bad_count = 0;
    num_checks = 0;
    seed = 32'h0A169D0B;
    adr = '{pemffl_pkg::OFF_COR_MSK, pemffl_pkg::OFF_RP_MSK, pemffl_pkg::OFF_FAT_LOG, 12'h158};
    do_reset(1'b1, 20);
    for (int i = 0; i < 4; i++)
      reg_rd(i);
    for (int i = 0; i < 4; i++)
      reg_wr(i, 32'hFFFF_FFFF, 4'hF);
    for (int i = 0; i < 4; i++)
      reg_rd(i);
    evt(5'h1F, 3'h7, 12'h0, 12'h0, 12'hFFF);
    $display("test reset and reserved done");
    for (int i = 0; i < 5; i++)
    begin
      reg_wr(0, 32'h1 << ((i == 0) ? 12 : (i == 1) ? 8 : (i == 2) ? 7 : (i == 3) ? 6 : 0), 4'hF);
      evt(5'h1F, 3'h0, 12'h0, 12'h0, 12'hFFF);
    end
    reg_wr(0, 32'h0000_11C1, 4'h1);
    evt(5'h1F, 3'h0, 12'h0, 12'h0, 12'hFFF);
    reg_wr(2, 32'hFFFF_FFFF, 4'hF);
    for (int i = 2; i >= 0; i--)
    begin
      reg_wr(1, 32'h1 << i, 4'hF);
      evt(5'h0, 3'h7, 12'h0, 12'h0, 12'hFFF);
    end
    $display("test masks done");
    reg_wr(1, 32'h0, 4'hF);
    reg_wr(2, 32'hFFFF_FFFF, 4'hF);
    for (int i = 0; i < 12; i++)  // training type only logged, never relied upon
    begin
      evt(5'h0, 3'h0, 12'h1 << i, 12'h0, ~(12'h1 << i));
      evt(5'h0, 3'h0, 12'h1 << i, 12'h1 << i, 12'hFFF);
      evt(5'h0, 3'h0, 12'h1 << i, 12'h0, 12'hFFF);
    end
    evt(5'h0, 3'h4, 12'hFFF, 12'h0, 12'hFFF);
    reg_wr(2, 32'h0, 4'hF);
    cyc(1'b1, 1'b1, 2, 32'h0000_1001, 4'hF, 5'h0, 3'h0, 12'h800, 12'h0, 12'hFFF);
    reg_wr(2, 32'h0000_0F00, 4'h2);
    reg_rd(2);
    $display("test first fatal log done");
    reg_wr(0, 32'h0000_1000, 4'hF);
    reg_wr(1, 32'h0000_0005, 4'hF);
    do_reset(1'b0, 2);
    for (int i = 0; i < 3; i++)
      reg_rd(i);
    do_reset(1'b1, 2);
    reg_rd(2);
    $display("test resets done");
    for (int n = 0; n < 400; n++)
    begin
      r0 = $random(seed);
      r1 = $random(seed);
      r2 = $random(seed);
      cyc(r0[2] & r0[3], r0[4], int'(r0[1:0]), r1, r0[8:5], r0[13:9], r0[16:14], r2[11:0] & r1[27:16],
          r2[23:12] & r0[31:20], r2[31:20]);
    end
    $display("test random traffic done");
    do_reset(1'b0, 3);
    if (rd_q.size() != 0 || det_q.size() != 0)
    begin
      bad_count++;
      $display("Error pending notes expected 0 seen %0d", rd_q.size() + det_q.size());
    end
    print_verdict();
  end

endmodule : pcie_error_mask_first_fatal_log_tb
